// ### hw/rtcais_ctrl.sv
// Alarm interrupt, square-wave routing and status flag logic of the clock.
`timescale 1ns/1ns
`include "rtcais_consts.svh"
// Overview of operation
// - Rate field picks 1Hz to 8.192kHz wave.
// - Pin select chooses wave or alarm interrupts.
// - Alarm-two enable bit gates alarm-two interrupt.
// - Alarm-one enable bit gates alarm-one interrupt.
// - Oscillator-halt flag sets on stop, stays set.
// - Halt flag sets at power-up, battery disable.
// - Fixed clock pin released unless enable set.
// - Busy flag rises with conversion request, clears idle.
// - Alarm-two match sets alarm-two flag.
// - Alarm-two flag drives pin when enabled.
// - Writing zero clears alarm-two flag only.
// - Alarm-one match sets alarm-one flag.
// - Alarm-one flag drives pin when enabled.
// - Writing zero clears alarm-one flag only.
// - Conversion end clears busy, and trigger too unless control is written in that cycle.
module rtcais_ctrl #(
  parameter int unsigned SQW_HALF_1HZ = `RTCAIS_CLK_HZ / (2 * `RTCAIS_SQW_F0_HZ),
  parameter int unsigned SQW_HALF_1K = `RTCAIS_CLK_HZ / (2 * `RTCAIS_SQW_F1_HZ),
  parameter int unsigned SQW_HALF_4K = `RTCAIS_CLK_HZ / (2 * `RTCAIS_SQW_F2_HZ),
  parameter int unsigned SQW_HALF_8K = `RTCAIS_CLK_HZ / (2 * `RTCAIS_SQW_F3_HZ)
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [4:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic alarm_one_match_in,
  input wire logic alarm_two_match_in,
  input wire logic osc_stopped_in,
  input wire logic on_battery_in,
  input wire logic tcxo_periodic_req_in,
  input wire logic tcxo_idle_in,
  output logic temp_temp_measure_trigger_req_out,
  output logic irq_or_wave_out,
  output logic irq_or_wave_oe_n_out,
  output logic fixed_clock_out,
  output logic fixed_clock_oe_n_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.
  function automatic logic [`RTCAIS_CNT_W-1:0] sqw_half(input rtcais_pkg::rtcais_rate_t r);
    case (r)
      2'h0: sqw_half = `RTCAIS_CNT_W'(SQW_HALF_1HZ);
      2'h1: sqw_half = `RTCAIS_CNT_W'(SQW_HALF_1K);
      2'h2: sqw_half = `RTCAIS_CNT_W'(SQW_HALF_4K);
      default: sqw_half = `RTCAIS_CNT_W'(SQW_HALF_8K);
    endcase
  endfunction

  function automatic logic sticky_w0c(input logic flag, input logic wr, input logic wbit,
                                      input logic set);
    sticky_w0c = (flag & ~(wr & ~wbit)) | set;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register storage.
  logic [7:0] ctl;
  logic osc_halt_flag;
  logic fixed_clock_out_enable;
  logic alarm_one_flag;
  logic alarm_two_flag;
  logic tcxo_busy_flag;
  logic wr_ctl;
  logic wr_st;
  logic temp_measure_trigger_accept;
  logic temp_measure_trigger_start;
  logic temp_measure_trigger_done;
  rtcais_pkg::rtcais_temp_measure_trigger_e temp_measure_trigger_state;
  rtcais_pkg::rtcais_temp_measure_trigger_e next_temp_measure_trigger_state;

  assign wr_ctl = reg_wr_in && (reg_addr_in == `RTCAIS_ADDR_CONTROL);
  assign wr_st = reg_wr_in && (reg_addr_in == `RTCAIS_ADDR_STATUS);
  assign tcxo_busy_flag = (temp_measure_trigger_state == rtcais_pkg::RTCAIS_TEMP_MEASURE_TRIGGER_BUSY);
  assign temp_measure_trigger_accept = wr_ctl && reg_wdata_in[`RTCAIS_CTL_TEMP_MEASURE_TRIGGER] && !tcxo_busy_flag;
  assign temp_measure_trigger_start = !tcxo_busy_flag && (temp_measure_trigger_accept || tcxo_periodic_req_in);
  assign temp_measure_trigger_done = tcxo_busy_flag && tcxo_idle_in;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctl <= `RTCAIS_CONTROL_RESET;
    end else begin
      if (wr_ctl) begin
        ctl <= reg_wdata_in;
        ctl[`RTCAIS_CTL_TEMP_MEASURE_TRIGGER] <= ctl[`RTCAIS_CTL_TEMP_MEASURE_TRIGGER] | temp_measure_trigger_accept;
      end else if (temp_measure_trigger_done) begin
        ctl[`RTCAIS_CTL_TEMP_MEASURE_TRIGGER] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Temperature conversion sequencing.
  always_comb begin
    next_temp_measure_trigger_state = temp_measure_trigger_state;
    case (temp_measure_trigger_state)
      rtcais_pkg::RTCAIS_TEMP_MEASURE_TRIGGER_IDLE: begin
        if (temp_measure_trigger_start) begin
          next_temp_measure_trigger_state = rtcais_pkg::RTCAIS_TEMP_MEASURE_TRIGGER_BUSY;
        end
      end
      rtcais_pkg::RTCAIS_TEMP_MEASURE_TRIGGER_BUSY: begin
        if (tcxo_idle_in) begin
          next_temp_measure_trigger_state = rtcais_pkg::RTCAIS_TEMP_MEASURE_TRIGGER_IDLE;
        end
      end
      default: next_temp_measure_trigger_state = rtcais_pkg::RTCAIS_TEMP_MEASURE_TRIGGER_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      temp_measure_trigger_state <= rtcais_pkg::RTCAIS_TEMP_MEASURE_TRIGGER_IDLE;
      temp_temp_measure_trigger_req_out <= 1'b0;
    end else begin
      temp_measure_trigger_state <= next_temp_measure_trigger_state;
      temp_temp_measure_trigger_req_out <= temp_measure_trigger_start;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      osc_halt_flag <= 1'(`RTCAIS_STATUS_RESET >> `RTCAIS_ST_OSF);
    end else if (osc_stopped_in || (ctl[`RTCAIS_CTL_OSC_DIS] && on_battery_in)) begin
      osc_halt_flag <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fixed_clock_out_enable <= 1'b1;
    end else if (wr_st) begin
      fixed_clock_out_enable <= reg_wdata_in[`RTCAIS_ST_EN32K];
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      alarm_one_flag <= 1'b0;
      alarm_two_flag <= 1'b0;
    end else begin
      alarm_one_flag <= sticky_w0c(alarm_one_flag, wr_st, reg_wdata_in[`RTCAIS_ST_A1F],
                                   alarm_one_match_in);
      alarm_two_flag <= sticky_w0c(alarm_two_flag, wr_st, reg_wdata_in[`RTCAIS_ST_A2F],
                                   alarm_two_match_in);
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `RTCAIS_ADDR_CONTROL: reg_rdata_out <= ctl;
        `RTCAIS_ADDR_STATUS: reg_rdata_out <= {osc_halt_flag, 3'h0, fixed_clock_out_enable,
                                               tcxo_busy_flag, alarm_two_flag, alarm_one_flag};
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wave generators.
  logic [`RTCAIS_CNT_W-1:0] sqw_cnt;
  logic [`RTCAIS_CNT_W-1:0] sqw_lim;
  logic sqw_wave;
  logic [10:0] clk32_cnt;
  logic clk32_wave;

  assign sqw_lim = sqw_half(ctl[`RTCAIS_CTL_RS_HI:`RTCAIS_CTL_RS_LO]) - `RTCAIS_CNT_W'(1);

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sqw_cnt <= '0;
      sqw_wave <= 1'b0;
    end else if (sqw_cnt >= sqw_lim) begin
      sqw_cnt <= '0;
      sqw_wave <= ~sqw_wave;
    end else begin
      sqw_cnt <= sqw_cnt + `RTCAIS_CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      clk32_cnt <= '0;
      clk32_wave <= 1'b0;
    end else if (clk32_cnt >= 11'(`RTCAIS_CLK32_HALF - 1)) begin
      clk32_cnt <= '0;
      clk32_wave <= ~clk32_wave;
    end else begin
      clk32_cnt <= clk32_cnt + 11'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Open-drain pins: the drive value is always low, the enable shapes the level.
  logic alarm_irq;
  assign alarm_irq = (alarm_one_flag & ctl[`RTCAIS_CTL_ALARM_ONE_IRQ_ENABLE]) |
                     (alarm_two_flag & ctl[`RTCAIS_CTL_ALARM_TWO_IRQ_ENABLE]);

  assign irq_or_wave_out = 1'b0;
  assign fixed_clock_out = 1'b0;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_or_wave_oe_n_out <= 1'b1;
    end else if (ctl[`RTCAIS_CTL_PIN_FUNCTION_SELECT]) begin
      irq_or_wave_oe_n_out <= ~alarm_irq;
    end else if (on_battery_in && !ctl[`RTCAIS_CTL_BBSQW]) begin
      irq_or_wave_oe_n_out <= 1'b1;
    end else begin
      irq_or_wave_oe_n_out <= sqw_wave;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fixed_clock_oe_n_out <= 1'b1;
    end else begin
      fixed_clock_oe_n_out <= ~fixed_clock_out_enable | clk32_wave;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  a_a1_flag_set: assert property (alarm_one_match_in |=> alarm_one_flag)
    else $error("alarm one match did not set flag");
  a_a2_flag_set: assert property (alarm_two_match_in |=> alarm_two_flag)
    else $error("alarm two match did not set flag");
  a_a1_flag_clear: assert property (wr_st && !reg_wdata_in[`RTCAIS_ST_A1F] && !alarm_one_match_in
    |=> !alarm_one_flag) else $error("alarm one flag not cleared");
  a_a2_flag_clear: assert property (wr_st && !reg_wdata_in[`RTCAIS_ST_A2F] && !alarm_two_match_in
    |=> !alarm_two_flag) else $error("alarm two flag not cleared");
  a_flags_no_swset: assert property (!alarm_one_flag && !alarm_one_match_in
    |=> !alarm_one_flag) else $error("alarm one flag set without match");
  a_irq_assert: assert property (ctl[`RTCAIS_CTL_PIN_FUNCTION_SELECT] && alarm_irq |=> !irq_or_wave_oe_n_out)
    else $error("interrupt pin not asserted");
  a_irq_release: assert property (ctl[`RTCAIS_CTL_PIN_FUNCTION_SELECT] && !alarm_irq |=> irq_or_wave_oe_n_out)
    else $error("interrupt pin not released");
  a_wave_route: assert property (!ctl[`RTCAIS_CTL_PIN_FUNCTION_SELECT] && !on_battery_in
    |=> irq_or_wave_oe_n_out == $past(sqw_wave)) else $error("square wave not routed");
  a_osf_sticky: assert property (osc_halt_flag |=> osc_halt_flag)
    else $error("halt flag dropped");
  a_osf_battery: assert property (ctl[`RTCAIS_CTL_OSC_DIS] && on_battery_in |=> osc_halt_flag)
    else $error("halt flag not set on battery disable");
  a_clk_released: assert property (!fixed_clock_out_enable |=> fixed_clock_oe_n_out)
    else $error("fixed clock pin driven while disabled");
  a_busy_on_req: assert property (temp_temp_measure_trigger_req_out |-> tcxo_busy_flag)
    else $error("busy flag not raised with request");
  a_temp_measure_trigger_end: assert property (temp_measure_trigger_done |=> !tcxo_busy_flag && !ctl[`RTCAIS_CTL_TEMP_MEASURE_TRIGGER])
    else $error("conversion end left trigger or busy set");
  a_sqw_period: assert property (sqw_cnt == sqw_lim |=> sqw_wave != $past(sqw_wave))
    else $error("square wave did not toggle at rate count");

  c_alarm_irq: cover property (ctl[`RTCAIS_CTL_PIN_FUNCTION_SELECT] && !irq_or_wave_oe_n_out);
  c_temp_measure_trigger_done: cover property (temp_measure_trigger_done && ctl[`RTCAIS_CTL_TEMP_MEASURE_TRIGGER]);
  c_flag_clear: cover property (alarm_one_flag ##1 !alarm_one_flag);
  c_wave_toggle: cover property (!ctl[`RTCAIS_CTL_PIN_FUNCTION_SELECT] && $changed(sqw_wave));

endmodule

// ### hw/rtcais_consts.svh
// Named constants for the alarm interrupt and status control block.
`ifndef RTCAIS_CONSTS_SVH
`define RTCAIS_CONSTS_SVH
`define RTCAIS_ADDR_CONTROL 5'h0E
`define RTCAIS_ADDR_STATUS 5'h0F
`define RTCAIS_CONTROL_RESET 8'h1C
`define RTCAIS_STATUS_RESET 8'h88
`define RTCAIS_CTL_OSC_DIS 7
`define RTCAIS_CTL_BBSQW 6
`define RTCAIS_CTL_TEMP_MEASURE_TRIGGER 5
`define RTCAIS_CTL_RS_HI 4
`define RTCAIS_CTL_RS_LO 3
`define RTCAIS_CTL_PIN_FUNCTION_SELECT 2
`define RTCAIS_CTL_ALARM_TWO_IRQ_ENABLE 1
`define RTCAIS_CTL_ALARM_ONE_IRQ_ENABLE 0
`define RTCAIS_ST_OSF 7
`define RTCAIS_ST_EN32K 3
`define RTCAIS_ST_BSY 2
`define RTCAIS_ST_A2F 1
`define RTCAIS_ST_A1F 0
`define RTCAIS_CLK_HZ 100000000
`define RTCAIS_SQW_F0_HZ 1
`define RTCAIS_SQW_F1_HZ 1024
`define RTCAIS_SQW_F2_HZ 4096
`define RTCAIS_SQW_F3_HZ 8192
`define RTCAIS_CLK32_F_HZ 32768
`define RTCAIS_CLK32_HALF (`RTCAIS_CLK_HZ / (2 * `RTCAIS_CLK32_F_HZ))
`define RTCAIS_CNT_W 26
`endif

// ### hw/rtcais_pkg.sv
// Types shared by the alarm interrupt and status control block.
package rtcais_pkg;
  typedef enum logic [1:0] {
    RTCAIS_TEMP_MEASURE_TRIGGER_IDLE = 2'h1,
    RTCAIS_TEMP_MEASURE_TRIGGER_BUSY = 2'h2
  } rtcais_temp_measure_trigger_e;
  typedef logic [1:0] rtcais_rate_t;
endpackage

// ### sim/rtcais_host_model.sv
// Host model that reaches the block registers through its strobe port.
`timescale 1ns/1ns
module rtcais_host_model (
  input wire logic sys_clk_in,
  input wire logic [7:0] reg_rdata_in,
  output logic [4:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_wr_out,
  output logic reg_rd_out
);
  initial begin
    reg_addr_out = 5'h00;
    reg_wdata_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
  end
  // Released address and data show the inverse of the last value.
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    #1;
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = 1'b1;
    @(posedge sys_clk_in);
    #1;
    reg_wr_out = 1'b0;
    reg_addr_out = ~a;
    reg_wdata_out = ~d;
  endtask
  task automatic rd_reg(input logic [4:0] a, output logic [7:0] d);
    @(posedge sys_clk_in);
    #1;
    reg_addr_out = a;
    reg_rd_out = 1'b1;
    @(posedge sys_clk_in);
    #1;
    reg_rd_out = 1'b0;
    reg_addr_out = ~a;
    d = reg_rdata_in;
  endtask
endmodule

// ### sim/testbench.sv
// Self-checking bench for the alarm interrupt and status control block.
`timescale 1ns/1ns
`include "rtcais_consts.svh"
module testbench;
  logic sys_clk_in;
  logic rst_in;
  logic [4:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic wr, rd, m1, m2, ostop, batt, preq, idle;
  logic creq, iw, iw_oe_n, fc, fc_oe_n;
  int failures = 0;
  int n_checks = 0;
  int p;
  int half_tab [4] = '{10, 8, 6, 4};
  rtcais_ctrl #(.SQW_HALF_1HZ(10), .SQW_HALF_1K(8), .SQW_HALF_4K(6), .SQW_HALF_8K(4)
  ) i_rtcais_ctrl (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .alarm_one_match_in(m1), .alarm_two_match_in(m2), .osc_stopped_in(ostop),
    .on_battery_in(batt), .tcxo_periodic_req_in(preq), .tcxo_idle_in(idle),
    .temp_temp_measure_trigger_req_out(creq), .irq_or_wave_out(iw), .irq_or_wave_oe_n_out(iw_oe_n),
    .fixed_clock_out(fc), .fixed_clock_oe_n_out(fc_oe_n));
  rtcais_host_model i_rtcais_host_model (
    .sys_clk_in(sys_clk_in), .reg_rdata_in(rdata), .reg_addr_out(addr),
    .reg_wdata_out(wdata), .reg_wr_out(wr), .reg_rd_out(rd));
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic wc(input logic [7:0] d);
    i_rtcais_host_model.wr_reg(`RTCAIS_ADDR_CONTROL, d);
  endtask
  task automatic ws(input logic [7:0] d);
    i_rtcais_host_model.wr_reg(`RTCAIS_ADDR_STATUS, d);
  endtask
  task automatic rchk(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] v;
    i_rtcais_host_model.rd_reg(a, v);
    chk(v, exp);
  endtask
  task automatic pm(input int j);
    if (j == 0) m1 = 1'b1;
    else m2 = 1'b1;
    cyc(1);
    m1 = 1'b0;
    m2 = 1'b0;
    cyc(2);
  endtask
  task automatic lows(input int n, output int k);
    k = 0;
    repeat (n) begin
      cyc(1);
      if (fc_oe_n === 1'b0) k++;
    end
  endtask
  task automatic period(output int n);
    int k;
    k = 0;
    while (iw_oe_n !== 1'b1 && k < 100) begin cyc(1); k++; end
    while (iw_oe_n !== 1'b0 && k < 200) begin cyc(1); k++; end
    n = k;
    while (iw_oe_n !== 1'b1 && k < 300) begin cyc(1); k++; end
    while (iw_oe_n !== 1'b0 && k < 400) begin cyc(1); k++; end
    n = k - n;
  endtask
  task automatic final_report;
    if (failures == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    final_report();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_in = 1'b1;
    {m1, m2, ostop, batt, preq, idle} = 6'h00;
    cyc(4);
    rst_in = 1'b0;
    rchk(`RTCAIS_ADDR_CONTROL, `RTCAIS_CONTROL_RESET);
    rchk(`RTCAIS_ADDR_STATUS, `RTCAIS_STATUS_RESET);
    rchk(5'h03, 8'h00);
    lows(3200, p);
    chk(8'(p > 0), 8'h01);
    wc(8'h3C);
    chk({7'h00, creq}, 8'h01);
    rchk(`RTCAIS_ADDR_CONTROL, 8'h3C);
    rchk(`RTCAIS_ADDR_STATUS, 8'h8C);
    idle = 1'b1;
    cyc(1);
    idle = 1'b0;
    cyc(1);
    rchk(`RTCAIS_ADDR_CONTROL, 8'h1C);
    rchk(`RTCAIS_ADDR_STATUS, 8'h88);
    preq = 1'b1;
    cyc(1);
    preq = 1'b0;
    chk({7'h00, creq}, 8'h01);
    wc(8'h3C);
    chk({7'h00, creq}, 8'h00);
    rchk(`RTCAIS_ADDR_CONTROL, 8'h1C);
    rchk(`RTCAIS_ADDR_STATUS, 8'h8C);
    idle = 1'b1;
    cyc(1);
    idle = 1'b0;
    rchk(`RTCAIS_ADDR_STATUS, 8'h88);
    for (int j = 0; j < 2; j++) begin
      wc(8'h04 | (8'h01 << j));
      pm(j);
      chk({7'h00, iw_oe_n}, 8'h00);
      ws(8'hFF);
      rchk(`RTCAIS_ADDR_STATUS, 8'h88 | (8'h01 << j));
      chk({7'h00, iw_oe_n}, 8'h00);
      ws(8'h08);
      cyc(2);
      chk({7'h00, iw_oe_n}, 8'h01);
      wc(8'h04);
      pm(j);
      chk({7'h00, iw_oe_n}, 8'h01);
      rchk(`RTCAIS_ADDR_STATUS, 8'h88 | (8'h01 << j));
      ws(8'h08);
    end
    for (int i = 0; i < 4; i++) begin
      wc(8'(i << 3));
      period(p);
      chk(8'(p), 8'(2 * half_tab[i]));
    end
    batt = 1'b1;
    cyc(2);
    chk({7'h00, iw_oe_n}, 8'h01);
    cyc(7);
    chk({7'h00, iw_oe_n}, 8'h01);
    batt = 1'b0;
    ws(8'h00);
    cyc(2);
    lows(3200, p);
    chk(8'(p), 8'h00);
    ostop = 1'b1;
    cyc(1);
    ostop = 1'b0;
    rchk(`RTCAIS_ADDR_STATUS, 8'h80);
    chk({6'h00, iw, fc}, 8'h00);
    rst_in = 1'b1;
    cyc(2);
    rst_in = 1'b0;
    rchk(`RTCAIS_ADDR_STATUS, `RTCAIS_STATUS_RESET);
    final_report();
  end
endmodule
